// File: design/arc_top.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Operation
// - right align puts bits 9:8 in high 1:0
// - left align puts bits 1:0 in low 7:6
// - left align puts bits 9:2 in high byte
// - source codes: free, comparator, int0, timers
// - source has no effect without auto trigger
// - auto trigger starts on selected flag rising
// - switching low source to high source triggers
// - switching to free running never triggers
// - comparator takes mux when enabled, converter off
// - disable bit forces pin input to zero
// - low byte read locks result until high read
// - alignment change takes effect at once
// - auto trigger enable allows edge starts
// - done flag set when result registers update
//////////////////////////////////////////////////////////////////////////////
module arc_top (
    // clocking
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [arc_pkg::ARC_AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [arc_pkg::ARC_DW-1:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [arc_pkg::ARC_AW-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [arc_pkg::ARC_DW-1:0] rdata,
    output logic [1:0] rresp,
    // analog converter core
    output logic conv_enable,
    output logic conv_start,
    output logic [arc_pkg::ARC_MUX_CH_W-1:0] conv_channel,
    input wire logic conv_done,
    input wire logic [arc_pkg::ARC_RES_W-1:0] conv_result,
    // on-chip trigger flags, codes 1 to 7 in order
    input wire logic [arc_pkg::ARC_NFLAG-2:0] trig_flags,
    // comparator negative input routing
    output logic cmp_use_mux,
    // analog pads
    input wire logic [arc_pkg::ARC_BW-1:0] pin_in,
    output logic [arc_pkg::ARC_BW-1:0] pin_buf_off,
    output logic [arc_pkg::ARC_BW-1:0] port_pin_value,
    // interrupt
    output logic irq
);
    import arc_pkg::*;
    default clocking arc_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    //////////////////////////////////////////////////////////////////////////
    // state
    logic en_ff; // converter enable
    logic auto_ff; // auto trigger enable
    logic busy_ff; // conversion in progress
    logic left_ff; // left alignment select
    logic [ARC_MUX_CH_W-1:0] ch_ff; // channel select
    logic cmp_mux_ff; // comparator mux enable
    logic [ARC_SRC_W-1:0] src_ff; // trigger source select
    logic [ARC_BW-1:0] dis_ff; // digital input disable
    logic [ARC_ST_W-1:0] st_ff; // sticky event bits
    logic [ARC_ST_W-1:0] msk_ff; // interrupt mask
    logic [ARC_RES_W-1:0] res_ff; // last accepted result
    logic lock_ff; // result update lock
    logic start_ff; // start pulse to core
    logic use_mux_ff; // comparator routing
    logic [ARC_BW-1:0] port_ff; // gated pin values
    // bus side
    logic aw_ff, w_ff, bvalid_ff, rvalid_ff;
    logic [ARC_AW-1:0] awaddr_ff;
    logic [ARC_BW-1:0] wbyte_ff;
    logic wlane_ff; // low byte lane strobed
    logic [1:0] bresp_ff, rresp_ff;
    logic [ARC_DW-1:0] rdata_ff;

    //////////////////////////////////////////////////////////////////////////
    // result presentation, combinational so alignment acts at once
    logic [ARC_BW-1:0] res_lo, res_hi;
    assign res_lo = left_ff ? {res_ff[1:0], 6'h00}
                            : res_ff[ARC_BW-1:0];
    assign res_hi = left_ff ? res_ff[ARC_RES_W-1:2]
                            : {6'h00, res_ff[9:8]};

    //////////////////////////////////////////////////////////////////////////
    // write decode; a write goes ahead once address and data are both held
    logic wr_go, wr_ok;
    logic wr_ctrl, wr_tsc, wr_mux, wr_dis, wr_st, wr_msk;
    assign wr_go = aw_ff && w_ff && !bvalid_ff;
    assign wr_ctrl = wr_go && wlane_ff && arc_hit(awaddr_ff, ARC_IDX_CTRL);
    assign wr_tsc = wr_go && wlane_ff && arc_hit(awaddr_ff, ARC_IDX_TSC);
    assign wr_mux = wr_go && wlane_ff && arc_hit(awaddr_ff, ARC_IDX_MUX);
    assign wr_dis = wr_go && wlane_ff && arc_hit(awaddr_ff, ARC_IDX_DIS);
    assign wr_st = wr_go && wlane_ff && arc_hit(awaddr_ff, ARC_IDX_IRQ_ST);
    assign wr_msk = wr_go && wlane_ff && arc_hit(awaddr_ff, ARC_IDX_IRQ_MSK);
    // result registers are read-only but a write there is not an error
    assign wr_ok = arc_hit(awaddr_ff, ARC_IDX_RES_LO)
                || arc_hit(awaddr_ff, ARC_IDX_RES_HI)
                || arc_hit(awaddr_ff, ARC_IDX_CTRL)
                || arc_hit(awaddr_ff, ARC_IDX_TSC)
                || arc_hit(awaddr_ff, ARC_IDX_MUX)
                || arc_hit(awaddr_ff, ARC_IDX_DIS)
                || arc_hit(awaddr_ff, ARC_IDX_IRQ_ST)
                || arc_hit(awaddr_ff, ARC_IDX_IRQ_MSK);
    assign awready = ce && !aw_ff && !bvalid_ff;
    assign wready = ce && !w_ff && !bvalid_ff;

    //////////////////////////////////////////////////////////////////////////
    // read decode
    logic ar_go, rd_lo, rd_hi, rd_ok;
    logic [ARC_BW-1:0] rd_byte;
    assign arready = ce && !rvalid_ff;
    assign ar_go = arvalid && arready;
    assign rd_lo = arc_hit(araddr, ARC_IDX_RES_LO);
    assign rd_hi = arc_hit(araddr, ARC_IDX_RES_HI);
    assign rd_byte =
        rd_lo ? res_lo :
        rd_hi ? res_hi :
        arc_hit(araddr, ARC_IDX_CTRL) ?
            {en_ff, busy_ff, auto_ff, st_ff[ARC_ST_DONE], 4'h0} :
        arc_hit(araddr, ARC_IDX_TSC) ?
            {1'h0, cmp_mux_ff, 3'h0, src_ff} :
        arc_hit(araddr, ARC_IDX_MUX) ? {2'h0, left_ff, 1'h0, ch_ff} :
        arc_hit(araddr, ARC_IDX_DIS) ? dis_ff :
        arc_hit(araddr, ARC_IDX_IRQ_ST) ? {6'h00, st_ff} :
        arc_hit(araddr, ARC_IDX_IRQ_MSK) ? {6'h00, msk_ff} : ARC_RST_BYTE;
    assign rd_ok = rd_lo || rd_hi || arc_hit(araddr, ARC_IDX_CTRL)
                || arc_hit(araddr, ARC_IDX_TSC)
                || arc_hit(araddr, ARC_IDX_MUX)
                || arc_hit(araddr, ARC_IDX_DIS)
                || arc_hit(araddr, ARC_IDX_IRQ_ST)
                || arc_hit(araddr, ARC_IDX_IRQ_MSK);

    //////////////////////////////////////////////////////////////////////////
    // conversion start and completion
    logic trig_edge, auto_start, sw_start, start_req, done_in, res_take;
    logic [ARC_ST_W-1:0] st_set, st_clr, nxt_st;
    arc_trig u_trig (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .src(src_ff),
        .flags({trig_flags, st_ff[ARC_ST_DONE]}),
        .edge_det(trig_edge)
    );
    // the source only matters while auto triggering is on
    assign auto_start = auto_ff && trig_edge;
    assign sw_start = wr_ctrl && wbyte_ff[ARC_CTL_START];
    // a start while busy is dropped; the core runs one at a time
    assign start_req = en_ff && !busy_ff && (sw_start || auto_start);
    assign done_in = conv_done && busy_ff && en_ff;
    // a locked result is lost, as the register holds the older value
    assign res_take = done_in && !lock_ff;
    assign st_set = {start_req && auto_start, res_take};
    assign st_clr = (wr_st ? wbyte_ff[ARC_ST_W-1:0] : 2'h0)
                  | (wr_ctrl && wbyte_ff[ARC_CTL_DONE] ? 2'h1 : 2'h0);
    assign nxt_st = (st_ff & ~st_clr) | st_set; // set wins over clear

    // control registers written by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_ff <= 1'b0;
            auto_ff <= 1'b0;
            left_ff <= 1'b0;
            ch_ff <= '0;
            cmp_mux_ff <= 1'b0;
            src_ff <= ARC_SRC_FREE;
            dis_ff <= ARC_RST_BYTE;
            msk_ff <= '0;
        end else if (ce) begin
            if (wr_ctrl) begin
                en_ff <= wbyte_ff[ARC_CTL_EN];
                auto_ff <= wbyte_ff[ARC_CTL_AUTO];
            end
            if (wr_tsc) begin
                cmp_mux_ff <= wbyte_ff[ARC_TSC_CMP];
                src_ff <= wbyte_ff[ARC_SRC_W-1:0];
            end
            if (wr_mux) begin
                left_ff <= wbyte_ff[ARC_MUX_LEFT];
                ch_ff <= wbyte_ff[ARC_MUX_CH_W-1:0];
            end
            if (wr_dis) dis_ff <= wbyte_ff;
            if (wr_msk) msk_ff <= wbyte_ff[ARC_ST_W-1:0];
        end
    end

    // conversion state, result capture and read lock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_ff <= 1'b0;
            start_ff <= 1'b0;
            res_ff <= '0;
            lock_ff <= 1'b0;
            st_ff <= '0;
        end else if (ce) begin
            start_ff <= start_req;
            // turning the converter off aborts a running conversion
            if (!en_ff || done_in) busy_ff <= 1'b0;
            else if (start_req) busy_ff <= 1'b1;
            if (res_take) res_ff <= conv_result;
            if (ar_go && rd_lo) lock_ff <= 1'b1;
            else if (ar_go && rd_hi) lock_ff <= 1'b0;
            st_ff <= nxt_st;
        end
    end

    // comparator routing and gated pad inputs
    logic [ARC_BW-1:0] pin_sync;
    arc_sync #(.W(ARC_BW)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .d(pin_in),
        .q(pin_sync)
    );
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            use_mux_ff <= 1'b0;
            port_ff <= ARC_RST_BYTE;
        end else if (ce) begin
            use_mux_ff <= cmp_mux_ff && !en_ff;
            port_ff <= pin_sync & ~dis_ff;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // bus slave handshakes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= '0;
            wbyte_ff <= ARC_RST_BYTE;
            wlane_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= ARC_RESP_OKAY;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_ff <= 1'b1;
                awaddr_ff <= awaddr;
            end else if (wr_go) aw_ff <= 1'b0;
            if (wvalid && wready) begin
                w_ff <= 1'b1;
                wbyte_ff <= wdata[ARC_BW-1:0];
                wlane_ff <= wstrb[0];
            end else if (wr_go) w_ff <= 1'b0;
            if (wr_go) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? ARC_RESP_OKAY : ARC_RESP_SLVERR;
            end else if (bready) bvalid_ff <= 1'b0;
        end
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= ARC_ZERO_WORD;
            rresp_ff <= ARC_RESP_OKAY;
        end else if (ce) begin
            if (ar_go) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= {24'h00_0000, rd_byte};
                rresp_ff <= rd_ok ? ARC_RESP_OKAY : ARC_RESP_SLVERR;
            end else if (rready) rvalid_ff <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // outputs
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign conv_enable = en_ff;
    assign conv_start = start_ff;
    assign conv_channel = ch_ff;
    assign cmp_use_mux = use_mux_ff;
    assign pin_buf_off = dis_ff;
    assign port_pin_value = port_ff;
    assign irq = |(st_ff & msk_ff);

    //////////////////////////////////////////////////////////////////////////
    // checks
    right_hi_a: assert property (
        !left_ff |-> res_hi[1:0] == res_ff[9:8] && res_hi[7:2] == 6'h00)
        else $error("right aligned high byte wrong");
    left_lo_a: assert property (
        left_ff |-> res_lo[7:6] == res_ff[1:0] && res_lo[5:0] == 6'h00)
        else $error("left aligned low byte wrong");
    left_hi_a: assert property (
        left_ff |-> res_hi == res_ff[9:2])
        else $error("left aligned high byte wrong");
    no_auto_a: assert property (
        (ce && !auto_ff && !sw_start) |=> !conv_start)
        else $error("start without auto trigger");
    edge_start_a: assert property (
        (ce && auto_ff && trig_edge && en_ff && !busy_ff) |=> conv_start)
        else $error("trigger edge gave no start");
    cmp_route_a: assert property (
        (ce && cmp_mux_ff && !en_ff) |=> cmp_use_mux)
        else $error("comparator not routed to mux");
    pin_zero_a: assert property (
        ce ##1 ce |-> (port_pin_value & $past(dis_ff)) == 8'h00)
        else $error("disabled pin reads one");
    sequence s_lo_read;
        ce && ar_go && rd_lo;
    endsequence
    sequence s_done_locked;
        ce && lock_ff && done_in;
    endsequence
    lock_hold_a: assert property (
        (s_lo_read |=> lock_ff) and (s_done_locked |=> $stable(res_ff)))
        else $error("result changed while locked");
    done_flag_a: assert property (
        (ce && done_in && !lock_ff) |=> st_ff[ARC_ST_DONE]
            && res_ff == $past(conv_result))
        else $error("done flag or result not updated");
endmodule : arc_top

// File: design/arc_pkg.sv
package arc_pkg;
    // bus geometry
    localparam int unsigned ARC_DW = 32;
    localparam int unsigned ARC_AW = 12;
    localparam int unsigned ARC_BW = 8;
    localparam int unsigned ARC_RES_W = 10;
    localparam int unsigned ARC_NFLAG = 8;
    // register indices; byte address is four times the index
    localparam logic [7:0] ARC_IDX_RES_LO = 8'h78;
    localparam logic [7:0] ARC_IDX_RES_HI = 8'h79;
    localparam logic [7:0] ARC_IDX_CTRL = 8'h7A;
    localparam logic [7:0] ARC_IDX_TSC = 8'h7B;
    localparam logic [7:0] ARC_IDX_MUX = 8'h7C;
    localparam logic [7:0] ARC_IDX_DIS = 8'h7E;
    localparam logic [7:0] ARC_IDX_IRQ_ST = 8'h80;
    localparam logic [7:0] ARC_IDX_IRQ_MSK = 8'h81;
    // control register fields
    localparam int unsigned ARC_CTL_EN = 7;
    localparam int unsigned ARC_CTL_START = 6;
    localparam int unsigned ARC_CTL_AUTO = 5;
    localparam int unsigned ARC_CTL_DONE = 4;
    // multiplexer register fields
    localparam int unsigned ARC_MUX_LEFT = 5;
    localparam int unsigned ARC_MUX_CH_W = 4;
    // trigger and comparator control fields
    localparam int unsigned ARC_TSC_CMP = 6;
    localparam int unsigned ARC_SRC_W = 3;
    localparam logic [2:0] ARC_SRC_FREE = 3'h0;
    // interrupt status fields
    localparam int unsigned ARC_ST_W = 2;
    localparam int unsigned ARC_ST_DONE = 0;
    localparam int unsigned ARC_ST_TRIG = 1;
    // reset values and responses
    localparam logic [7:0] ARC_RST_BYTE = 8'h00;
    localparam logic [1:0] ARC_RESP_OKAY = 2'h0;
    localparam logic [1:0] ARC_RESP_SLVERR = 2'h2;
    localparam logic [ARC_DW-1:0] ARC_ZERO_WORD = 32'h0000_0000;

    // byte address compare for a register index
    function automatic logic arc_hit(input logic [ARC_AW-1:0] addr,
                                     input logic [7:0] idx);
        arc_hit = (addr[ARC_AW-1:2] == {2'h0, idx});
    endfunction : arc_hit
endpackage : arc_pkg

// File: design/arc_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser for pad inputs
module arc_sync #(
    parameter int unsigned W = 8
) (
    // clocking
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    import arc_pkg::*;
    logic [W-1:0] meta_ff; // first stage, read only by second stage
    logic [W-1:0] sync_ff; // second stage

    // both stages freeze with the clock enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else if (ce) begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end
    assign q = sync_ff;
endmodule : arc_sync

// File: design/arc_trig.sv
`timescale 1ns/10ps
// trigger source select and rising edge detector
module arc_trig (
    // clocking
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // selection and flags, bit 0 is the conversion done flag
    input wire logic [arc_pkg::ARC_SRC_W-1:0] src,
    input wire logic [arc_pkg::ARC_NFLAG-1:0] flags,
    // one-cycle rising edge of the selected flag
    output logic edge_det
);
    import arc_pkg::*;
    default clocking trig_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic lvl_ff; // selected level one cycle ago
    logic [ARC_SRC_W-1:0] src_ff; // selection one cycle ago
    logic lvl; // selected level now
    logic to_free; // selection just moved to free running

    // switching sources compares against the old source's level, so a
    // move from a low flag to a high one is seen as an edge
    assign lvl = flags[src];
    assign to_free = (src == ARC_SRC_FREE) && (src_ff != ARC_SRC_FREE);
    assign edge_det = lvl && !lvl_ff && !to_free;

    // history registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl_ff <= 1'b0;
            src_ff <= ARC_SRC_FREE;
        end else if (ce) begin
            lvl_ff <= lvl;
            src_ff <= src;
        end
    end

    sequence s_src_to_free;
        (src == ARC_SRC_FREE) && (src_ff != ARC_SRC_FREE);
    endsequence
    free_quiet_a: assert property (
        s_src_to_free |-> !edge_det)
        else $error("edge on switch to free running");
    swap_edge_a: assert property (
        (ce && src != ARC_SRC_FREE && !flags[src] ##1
         src != $past(src) && src != ARC_SRC_FREE && flags[src])
        |-> edge_det)
        else $error("source swap low to high gave no edge");
endmodule : arc_trig

// File: tb/arc_top_bench.sv
`timescale 1ns/10ps
// count a comparison, report and count a mismatch
`define CHK(a, b) begin \
    total_checks++; \
    if ((a) !== (b)) begin \
        failures++; \
        $display("unexpected at %0t: got %h want %h", $time, a, b); \
    end \
end
module arc_top_bench;
    import arc_pkg::*;
    // clocking and bus
    logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid;
    logic bready, arvalid, arready, rvalid, rready;
    logic [2:0] awprot, arprot;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [ARC_AW-1:0] awaddr, araddr;
    logic [ARC_DW-1:0] wdata, rdata;
    // converter, flags and pads
    logic conv_enable, conv_start, conv_done, cmp_use_mux, irq;
    logic [ARC_MUX_CH_W-1:0] conv_channel;
    logic [ARC_RES_W-1:0] conv_result, r, r2;
    logic [ARC_NFLAG-2:0] trig_flags;
    logic [ARC_BW-1:0] pin_in, pin_buf_off, port_pin_value;
    // bench state: notes are {is_read, resp, data}
    logic [34:0] exp_q[$];
    logic [34:0] got, want;
    logic [31:0] lfsr_ff;
    int failures, total_checks, nstart, s0, k;

    arc_top arc_top_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .conv_enable(conv_enable), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_done(conv_done),
        .conv_result(conv_result), .trig_flags(trig_flags),
        .cmp_use_mux(cmp_use_mux), .pin_in(pin_in),
        .pin_buf_off(pin_buf_off), .port_pin_value(port_pin_value),
        .irq(irq));

    // 40 MHz clock
    initial begin
        aclk = 1'h0;
        forever #12.5 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////
    // scoreboard: each response retires the oldest note
    always @(negedge aclk) begin
        if (aresetn && ((bvalid && bready) || (rvalid && rready))) begin
            got = {rvalid, rvalid ? rresp : bresp,
                   rvalid ? rdata : ARC_ZERO_WORD};
            want = (exp_q.size() > 0) ? exp_q.pop_front() : ~got;
            `CHK(got, want)
        end
    end
    // start pulses are counted here, so no pulse slips past a test
    always @(negedge aclk) begin
        if (conv_start === 1'h1) nstart++;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    task automatic hang;
        failures++;
        $display("unexpected at %0t: no response", $time);
        final_report();
    endtask : hang
    // ready is sampled at the falling edge, where nothing moves
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      input logic [1:0] rs = ARC_RESP_OKAY);
        logic ta, tw, tb;
        int n;
        exp_q.push_back({1'h0, rs, ARC_ZERO_WORD});
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h00_0000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        for (n = 0; n < 64; n++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge aclk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            if (tb) break;
        end
        if (n == 64) hang();
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] d,
                      input logic [1:0] rs = ARC_RESP_OKAY);
        logic ta, tv;
        int n;
        exp_q.push_back({1'h1, rs, 24'h00_0000, d});
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'h1;
        for (n = 0; n < 64; n++) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tv = rvalid;
            @(posedge aclk);
            if (ta) arvalid <= 1'h0;
            if (tv) break;
        end
        if (n == 64) hang();
    endtask : rd
    // count start pulses seen since s0 over a settled window
    task automatic pulses(input int want_n);
        repeat (8) @(posedge aclk);
        @(negedge aclk);
        `CHK(nstart - s0, want_n)
        @(posedge aclk);
    endtask : pulses
    // converter answers, then its result lines go stale
    task automatic finish_conv(input logic [9:0] res);
        conv_result <= res;
        conv_done <= 1'h1;
        @(posedge aclk);
        conv_done <= 1'h0;
        conv_result <= ~res;
        @(posedge aclk);
    endtask : finish_conv
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        lfsr_step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_step
    function automatic logic [7:0] lo_b(input logic [9:0] v, input logic l);
        lo_b = l ? {v[1:0], 6'h00} : v[7:0];
    endfunction : lo_b
    function automatic logic [7:0] hi_b(input logic [9:0] v, input logic l);
        hi_b = l ? v[9:2] : {6'h00, v[9:8]};
    endfunction : hi_b

    ////////////////////////////////////////////////////////////////////
    // watchdog against a hang the tasks do not see
    initial begin
        repeat (90000) @(posedge aclk);
        hang();
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, conv_done} = '0;
        {awprot, arprot, awaddr, araddr, wdata, conv_result} = '0;
        {trig_flags, pin_in} = '0;
        ce = 1'h1;
        wstrb = 4'h1;
        lfsr_ff = 32'he6ec_4760;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        bready <= 1'h1;
        rready <= 1'h1;
        @(posedge aclk);
        // reset values, refused and read-only places
        rd(ARC_IDX_RES_LO, 8'h00);
        rd(ARC_IDX_RES_HI, 8'h00);
        rd(ARC_IDX_TSC, 8'h00);
        rd(8'hFF, 8'h00, ARC_RESP_SLVERR);
        wr(8'hFF, 8'h5A, ARC_RESP_SLVERR);
        wr(ARC_IDX_RES_HI, 8'hFF);
        rd(ARC_IDX_RES_HI, 8'h00);
        $display("test reset done");
        // software start, both alignments, masked then live irq
        wr(ARC_IDX_MUX, 8'h05);
        wr(ARC_IDX_CTRL, 8'h80);
        s0 = nstart;
        wr(ARC_IDX_CTRL, 8'hC0);
        pulses(1);
        lfsr_ff = lfsr_step(lfsr_ff);
        r = lfsr_ff[9:0];
        finish_conv(r);
        rd(ARC_IDX_IRQ_ST, 8'h01);
        `CHK({irq, conv_enable, conv_channel}, 6'h15)
        wr(ARC_IDX_IRQ_MSK, 8'h01);
        `CHK(irq, 1'h1)
        rd(ARC_IDX_RES_LO, lo_b(r, 1'h0));
        rd(ARC_IDX_RES_HI, hi_b(r, 1'h0));
        wr(ARC_IDX_MUX, 8'h25);
        rd(ARC_IDX_RES_LO, lo_b(r, 1'h1));
        rd(ARC_IDX_RES_HI, hi_b(r, 1'h1));
        wr(ARC_IDX_IRQ_ST, 8'h03);
        `CHK(irq, 1'h0)
        // a low-byte read holds the result until the high byte
        rd(ARC_IDX_RES_LO, lo_b(r, 1'h1));
        for (k = 0; k < 2; k++) begin
            s0 = nstart;
            wr(ARC_IDX_CTRL, 8'hC0);
            pulses(1);
            lfsr_ff = lfsr_step(lfsr_ff);
            r2 = lfsr_ff[9:0];
            finish_conv(r2);
        end
        rd(ARC_IDX_IRQ_ST, 8'h00);
        rd(ARC_IDX_RES_HI, hi_b(r, 1'h1));
        s0 = nstart;
        wr(ARC_IDX_CTRL, 8'hC0);
        pulses(1);
        finish_conv(r2);
        rd(ARC_IDX_RES_LO, lo_b(r2, 1'h1));
        rd(ARC_IDX_RES_HI, hi_b(r2, 1'h1));
        wr(ARC_IDX_IRQ_ST, 8'h03);
        $display("test result registers done");
        // source ignored while auto trigger is off
        wr(ARC_IDX_CTRL, 8'h80);
        wr(ARC_IDX_TSC, 8'h01);
        s0 = nstart;
        trig_flags <= 7'h01;
        pulses(0);
        trig_flags <= 7'h00;
        // source codes 1 to 7 each start one conversion on their rising flag
        wr(ARC_IDX_CTRL, 8'hA0);
        for (k = 1; k < 8; k++) begin
            wr(ARC_IDX_TSC, 8'(k));
            s0 = nstart;
            trig_flags <= 7'(1 << (k - 1));
            pulses(1);
            rd(ARC_IDX_IRQ_ST, 8'h02);
            trig_flags <= 7'h00;
            finish_conv(lfsr_ff[19:10]);
            wr(ARC_IDX_IRQ_ST, 8'h03);
        end
        // switch onto a raised flag, then to free running
        trig_flags <= 7'h02;
        s0 = nstart;
        wr(ARC_IDX_TSC, 8'h01);
        pulses(0);
        s0 = nstart;
        wr(ARC_IDX_TSC, 8'h02);
        pulses(1);
        finish_conv(lfsr_ff[9:0]);
        trig_flags <= 7'h00;
        s0 = nstart;
        wr(ARC_IDX_TSC, 8'h00);
        pulses(0);
        wr(ARC_IDX_IRQ_ST, 8'h03);
        $display("test trigger done");
        // comparator input follows mux enable only when converter off
        wr(ARC_IDX_CTRL, 8'h00);
        wr(ARC_IDX_TSC, 8'h40);
        rd(ARC_IDX_TSC, 8'h40);
        `CHK(cmp_use_mux, 1'h1)
        wr(ARC_IDX_CTRL, 8'h80);
        pulses(0);
        `CHK(cmp_use_mux, 1'h0)
        // disabled pads read zero
        for (k = 0; k < 4; k++) begin
            lfsr_ff = lfsr_step(lfsr_ff);
            wr(ARC_IDX_DIS, lfsr_ff[7:0]);
            pin_in <= lfsr_ff[15:8];
            s0 = nstart;
            pulses(0);
            `CHK(pin_buf_off, lfsr_ff[7:0])
            `CHK(port_pin_value, lfsr_ff[15:8] & ~lfsr_ff[7:0])
            rd(ARC_IDX_DIS, lfsr_ff[7:0]);
        end
        $display("test comparator and pads done");
        final_report();
    end
endmodule : arc_top_bench
